//--- inc/csis_pkg.sv
// Constants and types for the socket interrupt and status-change block
package csis_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_GEN_CTRL = 8'h03;
    localparam logic [7:0] OFF_STATUS_CHANGE = 8'h04;

    // Reset values
    localparam logic [7:0] GEN_CTRL_RESET = 8'h00;
    localparam logic [3:0] STATUS_CHANGE_RESET = 4'h0;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // General control field positions
    localparam int CTRL_RING_EN = 7;
    localparam int CTRL_RESET_RELEASE = 6;
    localparam int CTRL_CARD_IO = 5;
    localparam int CTRL_TO_PCI = 4;
    localparam int CTRL_FUNC_SEL_LSB = 0;

    // Status-change field positions
    localparam int STS_DETECT = 3;
    localparam int STS_READY = 2;
    localparam int STS_BAT_LOW = 1;
    localparam int STS_BAT_DEAD = 0;

    // Routing codes
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam int SEL_SMI = 2;

    ////////////////////////////////////////////////////////////////////////
    // Card pin vector positions
    localparam int PIN_W = 6;
    localparam int PIN_CD1 = 0;
    localparam int PIN_CD2 = 1;
    localparam int PIN_READY = 2;
    localparam int PIN_BVD1_RING = 3;
    localparam int PIN_BATTERY_DETECT_TWO = 4;
    localparam int PIN_FUNC_IRQ = 5;
    localparam logic [PIN_W-1:0] PIN_RESET = 6'h00;

    // Cycles after reset before edges count; covers the synchroniser fill
    localparam logic [1:0] ARM_DONE = 2'h3;
    localparam logic [1:0] ARM_RESET = 2'h0;

    typedef enum logic [1:0] {
        CSIS_BAT_DEAD,
        CSIS_BAT_LOW,
        CSIS_BAT_GOOD
    } csis_bat_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] card_status_change;
        logic [7:0] rdata;
        logic [PIN_W-1:0] prev;
        logic [1:0] arm;
        logic card_rst;
    } csis_state_t;

endpackage : csis_pkg

//--- verilog/csis_sync.sv
// Two-stage synchroniser for the socket card pins
`timescale 1ns/10ps

module csis_sync
    import csis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [PIN_W-1:0] pins_i,
    output logic [PIN_W-1:0] pins_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] safe;
    } csis_sync_state_t;

    csis_sync_state_t st_q;
    csis_sync_state_t st_d;

    // First stage feeds only the second stage
    always_comb
    begin
        st_d = st_q;
        st_d.meta = pins_i;
        st_d.safe = st_q.meta;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= '{meta: PIN_RESET, safe: PIN_RESET};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pins_o = st_q.safe;

endmodule : csis_sync

//--- verilog/csis_top.sv
// Socket interrupt routing, general control and status-change register
// Operation
// [R1] Control bit 7 enables ring indicate
// [R2] Control bit 6 low holds card reset
// [R3] Card reset acts on 16-bit cards only
// [R4] Control bit 5 marks memory or I/O
// [R5] Control bit 4 routes status interrupt PCI
// [R6] Bits 3-0 route functional interrupt line
// [R7] Select zero also routes status to PCI
// [R8] Disabled source bits always read zero
// [R9] Enabled event sets bit, raises interrupt
// [R10] Clear by read or write-one by mode
// [R11] Status bits 7-4 read zero
// [R12] Bit 3 set on either detect change
// [R13] Bit 2 on READY rise, memory only
// [R14] Bit 1 on battery low, memory only
// [R15] Bit 0 battery dead or status changed
// [R16] Ring enabled: bit 0 shows ring input
// [R17] Battery codes: 0x dead, 10 low
// [R18] Detect event needs detect enable
// [R19] Card pins synchronised before edge detection
// [R20] Interrupt holds while enabled bit set
`timescale 1ns/10ps

module csis_top
    import csis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic detect_event_enable_i,
    input wire logic ready_event_enable_i,
    input wire logic battery_low_enable_i,
    input wire logic battery_dead_enable_i,
    input wire logic [3:0] status_irq_line_select_i,
    input wire logic clear_by_write_one_i,
    input wire logic card_is_16bit_i,
    input wire logic card_detect_one_i,
    input wire logic card_detect_two_i,
    input wire logic card_ready_i,
    input wire logic battery_detect_one_ring_i,
    input wire logic battery_detect_two_i,
    input wire logic card_func_irq_i,
    output logic card_reset_o,
    output logic pci_irq_o,
    output logic system_management_irq_o,
    output logic [15:0] legacy_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    function automatic csis_bat_t bat_decode(input logic battery_detect_two,
                                             input logic bvd1);
        csis_bat_t b;
        b = CSIS_BAT_GOOD;
        if (!battery_detect_two)
        begin
            b = CSIS_BAT_DEAD;
        end
        else if (!bvd1)
        begin
            b = CSIS_BAT_LOW;
        end
        return b;
    endfunction : bat_decode

    // One-hot line vector; code 0 drives nothing, code 2 lands on SYSTEM_MANAGEMENT_IRQ
    function automatic logic [15:0] line_vec(input logic [3:0] sel);
        logic [15:0] v;
        v = 16'h0001 << sel;
        v[0] = 1'b0;
        return v;
    endfunction : line_vec

    ////////////////////////////////////////////////////////////////////////
    csis_state_t st_q;
    csis_state_t st_d;
    logic [PIN_W-1:0] pin_s;
    logic [PIN_W-1:0] chg;
    logic [PIN_W-1:0] rise;
    logic armed;
    logic is_io;
    logic ring_en;
    csis_bat_t bat_now;
    csis_bat_t bat_old;
    logic [3:0] en_v;
    logic [3:0] ev;
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic [3:0] csc_view;
    logic rd_csc;
    logic wr_csc;
    logic wr_ctrl;
    logic pend;
    logic to_pci;
    logic func_on;
    logic [15:0] route_v;

    csis_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .pins_i({card_func_irq_i, battery_detect_two_i,
                 battery_detect_one_ring_i, card_ready_i,
                 card_detect_two_i, card_detect_one_i}),
        .pins_o(pin_s)
    ); // see [R19]

    ////////////////////////////////////////////////////////////////////////
    // Card event detection
    assign chg = pin_s ^ st_q.prev;
    assign rise = pin_s & ~st_q.prev;
    assign armed = (st_q.arm == ARM_DONE);
    assign is_io = st_q.ctrl[CTRL_CARD_IO]; // see [R4]
    assign ring_en = st_q.ctrl[CTRL_RING_EN]; // see [R1]
    assign bat_now = bat_decode(pin_s[PIN_BATTERY_DETECT_TWO], pin_s[PIN_BVD1_RING]);
    assign bat_old = bat_decode(st_q.prev[PIN_BATTERY_DETECT_TWO],
                                st_q.prev[PIN_BVD1_RING]); // see [R17]
    assign en_v = {detect_event_enable_i, ready_event_enable_i,
                   battery_low_enable_i, battery_dead_enable_i};

    assign ev[STS_DETECT] = armed
        & (chg[PIN_CD1] | chg[PIN_CD2]); // see [R12]
    assign ev[STS_READY] = armed & ~is_io & rise[PIN_READY]; // see [R13]
    assign ev[STS_BAT_LOW] = armed & ~is_io
        & (bat_now == CSIS_BAT_LOW) & (bat_old != CSIS_BAT_LOW); // see [R14]
    // Ring mode shows the live pin, so no latched event then
    assign ev[STS_BAT_DEAD] = armed & ~ring_en & (is_io
        ? rise[PIN_BVD1_RING]
        : (bat_now == CSIS_BAT_DEAD) & (bat_old != CSIS_BAT_DEAD));
        // see [R15]

    assign set_v = ev & en_v; // see [R9] see [R18]

    ////////////////////////////////////////////////////////////////////////
    // Register access
    assign rd_csc = reg_rd_i && (reg_addr_i == OFF_STATUS_CHANGE);
    assign wr_csc = reg_wr_i && (reg_addr_i == OFF_STATUS_CHANGE);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_GEN_CTRL);

    always_comb
    begin
        clr_v = 4'h0;
        if (rd_csc && !clear_by_write_one_i)
        begin
            clr_v = 4'hf; // see [R10]
        end
        else if (wr_csc && clear_by_write_one_i)
        begin
            clr_v = reg_wdata_i[3:0]; // see [R10]
        end
    end

    assign csc_view[STS_DETECT] = st_q.card_status_change[STS_DETECT] & en_v[STS_DETECT];
    assign csc_view[STS_READY] = st_q.card_status_change[STS_READY] & ~is_io
        & en_v[STS_READY]; // see [R13]
    assign csc_view[STS_BAT_LOW] = st_q.card_status_change[STS_BAT_LOW] & ~is_io
        & en_v[STS_BAT_LOW]; // see [R14] see [R8]
    assign csc_view[STS_BAT_DEAD] = en_v[STS_BAT_DEAD] & (ring_en
        ? pin_s[PIN_BVD1_RING]
        : st_q.card_status_change[STS_BAT_DEAD]); // see [R16]

    always_comb
    begin
        st_d = st_q;
        st_d.prev = pin_s;
        if (!armed)
        begin
            st_d.arm = st_q.arm + 2'h1;
        end
        if (wr_ctrl)
        begin
            st_d.ctrl = reg_wdata_i;
        end
        // New events win over a clear in the same cycle
        st_d.card_status_change = ((st_q.card_status_change & ~clr_v) | set_v) & en_v; // see [R9]
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                OFF_GEN_CTRL: st_d.rdata = st_q.ctrl;
                OFF_STATUS_CHANGE: st_d.rdata = {4'h0, csc_view};
                // see [R11]
                default: st_d.rdata = READ_DATA_RESET;
            endcase
        end
        st_d.card_rst = card_is_16bit_i
            & ~st_q.ctrl[CTRL_RESET_RELEASE]; // see [R2] see [R3]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= '{ctrl: GEN_CTRL_RESET, card_status_change: STATUS_CHANGE_RESET,
                      rdata: READ_DATA_RESET, prev: PIN_RESET,
                      arm: ARM_RESET, card_rst: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt routing
    assign pend = |csc_view; // see [R20]
    assign to_pci = st_q.ctrl[CTRL_TO_PCI]
        | (st_q.ctrl[3:0] == SEL_NONE); // see [R5] see [R7]
    assign func_on = is_io & pin_s[PIN_FUNC_IRQ];

    always_comb
    begin
        route_v = 16'h0000;
        if (pend && !to_pci)
        begin
            route_v = line_vec(status_irq_line_select_i); // see [R5]
        end
        if (func_on)
        begin
            route_v = route_v | line_vec(st_q.ctrl[3:0]); // see [R6]
        end
    end

    assign pci_irq_o = pend & to_pci; // see [R9]
    assign system_management_irq_o = route_v[SEL_SMI];
    assign legacy_irq_o = route_v & ~(16'h0001 << SEL_SMI);
    assign reg_rdata_o = st_q.rdata;
    assign card_reset_o = st_q.card_rst;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    reserved_bits_zero_a: assert property ( // see [R11]
        $past(rd_csc) |-> reg_rdata_o[7:4] == 4'h0)
        else $error("status-change reserved bits not zero");

    reset_held_a: assert property ( // see [R2]
        (card_is_16bit_i && !st_q.ctrl[CTRL_RESET_RELEASE])
        |=> card_reset_o)
        else $error("card reset not asserted");

    reset_only_16bit_a: assert property ( // see [R3]
        !card_is_16bit_i |=> !card_reset_o)
        else $error("card reset driven without 16-bit card");

    disabled_reads_zero_a: assert property ( // see [R8]
        (rd_csc && !detect_event_enable_i) |=> !reg_rdata_o[STS_DETECT])
        else $error("disabled detect bit read as one");

    detect_sets_bit_a: assert property ( // see [R12]
        (armed && detect_event_enable_i && pin_s[PIN_CD1]
         != $past(pin_s[PIN_CD1]))
        |=> st_q.card_status_change[STS_DETECT] && (pend || !detect_event_enable_i))
        else $error("detect change not latched");

    io_ready_zero_a: assert property ( // see [R13]
        (rd_csc && is_io && !wr_ctrl) |=> !reg_rdata_o[STS_READY])
        else $error("ready bit set with I/O card");

    read_clear_a: assert property ( // see [R10]
        (rd_csc && !clear_by_write_one_i && set_v == 4'h0)
        |=> st_q.card_status_change == 4'h0)
        else $error("read did not clear status bits");

    select_zero_pci_a: assert property ( // see [R7]
        (pend && st_q.ctrl[3:0] == SEL_NONE) |-> pci_irq_o)
        else $error("select zero did not route to PCI");

    irq_holds_a: assert property ( // see [R20]
        (pci_irq_o && clr_v == 4'h0 && $stable(en_v) && !wr_ctrl
         && !ring_en) |=> pci_irq_o)
        else $error("status interrupt dropped while pending");

    func_route_a: assert property ( // see [R6]
        (func_on && st_q.ctrl[3:0] == 4'h5) |-> legacy_irq_o[5])
        else $error("functional interrupt not on selected line");

    smi_route_a: assert property ( // see [R6]
        (func_on && st_q.ctrl[3:0] == 4'h2) |-> system_management_irq_o)
        else $error("functional interrupt not on management line");

    status_line_a: assert property ( // see [R5]
        (pend && !to_pci && status_irq_line_select_i == 4'h5)
        |-> legacy_irq_o[5])
        else $error("status interrupt not on selected line");

    write_one_clear_a: assert property ( // see [R10]
        (wr_csc && clear_by_write_one_i && set_v == 4'h0)
        |=> (st_q.card_status_change & $past(reg_wdata_i[3:0])) == 4'h0)
        else $error("write-one did not clear status bits");

    disabled_no_latch_a: assert property ( // see [R18]
        !detect_event_enable_i |=> !st_q.card_status_change[STS_DETECT])
        else $error("detect bit latched while disabled");

    ready_sets_bit_a: assert property ( // see [R13]
        (armed && !is_io && ready_event_enable_i && rise[PIN_READY])
        |=> st_q.card_status_change[STS_READY])
        else $error("ready rise not latched");

    io_battery_zero_a: assert property ( // see [R14]
        (rd_csc && is_io && !wr_ctrl) |=> !reg_rdata_o[STS_BAT_LOW])
        else $error("battery low bit set with I/O card");

    ring_live_a: assert property ( // see [R16]
        (rd_csc && ring_en && battery_dead_enable_i)
        |=> reg_rdata_o[STS_BAT_DEAD] == $past(pin_s[PIN_BVD1_RING]))
        else $error("ring bit does not follow the ring input");

endmodule : csis_top

//--- testbench/csis_card_model.sv
// Behavioural 16-bit card driving the socket pins
`timescale 1ns/10ps

module csis_card_model (
    input wire logic ref_clk_i,
    input wire logic [5:0] want_i,
    output logic [5:0] pins_o
);
    ////////////////////////////////////////////////////////////////////////
    // Skewed off the edge, as a real card is not clocked by us
    // Battery pair: 0x dead, 10 low, 11 good
    initial pins_o = 6'h18;
    always @(posedge ref_clk_i) pins_o <= #3 want_i;
endmodule : csis_card_model

//--- testbench/card_socket_irq_status_tb_top.sv
// Self-checking bench for the socket interrupt and status-change block
`timescale 1ns/10ps
`define CHK(nm, e, s) \
    begin \
        total_checks++; \
        if ((s) !== (e)) \
        begin \
            n_mismatch++; \
            $display("Error %s expected %h seen %h", nm, e, s); \
        end \
    end

module card_socket_irq_status_tb_top
    import csis_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q, ctrl;
    logic wr = 1'b0, rd = 1'b0, wo1 = 1'b0, is16 = 1'b1;
    logic [3:0] en = 4'h0, ls = 4'h0;
    logic [5:0] want = 6'h18, pins;
    logic card_rst, pci, system_management_irq;
    logic [15:0] leg;
    logic [31:0] seed = 32'h891b;
    int n_mismatch = 0, total_checks = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    csis_card_model CARD (.ref_clk_i(ref_clk_i), .want_i(want), .pins_o(pins));
    csis_top DUT (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .detect_event_enable_i(en[3]), .ready_event_enable_i(en[2]),
        .battery_low_enable_i(en[1]), .battery_dead_enable_i(en[0]),
        .status_irq_line_select_i(ls), .clear_by_write_one_i(wo1),
        .card_is_16bit_i(is16), .card_detect_one_i(pins[PIN_CD1]),
        .card_detect_two_i(pins[PIN_CD2]), .card_ready_i(pins[PIN_READY]),
        .battery_detect_one_ring_i(pins[PIN_BVD1_RING]),
        .battery_detect_two_i(pins[PIN_BATTERY_DETECT_TWO]),
        .card_func_irq_i(pins[PIN_FUNC_IRQ]), .card_reset_o(card_rst),
        .pci_irq_o(pci), .system_management_irq_o(system_management_irq), .legacy_irq_o(leg)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Reference route as {pci, smi, irq15..irq0}
    function automatic logic [17:0] pick(logic [17:0] o, logic [3:0] n);
        if (n == 4'h2)
            o[16] = 1'b1;
        else if (n != 4'h0)
            o[n] = 1'b1;
        return o;
    endfunction : pick

    function automatic logic [17:0] route(logic [7:0] c, logic fi, logic st);
        logic [17:0] o;
        o = '0;
        if (st && (c[4] || c[3:0] == 4'h0))
            o[17] = 1'b1;
        else if (st)
            o = pick(o, ls);
        if (fi && c[5])
            o = pick(o, c[3:0]);
        return o;
    endfunction : route

    ////////////////////////////////////////////////////////////////////////
    task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask : rw

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rw(1'b0, a, 8'h00);
        `CHK("rdata", e, q)
    endtask : rd_chk

    task automatic wr_ctrl(input logic [7:0] v);
        ctrl = v;
        rw(1'b1, OFF_GEN_CTRL, v);
    endtask : wr_ctrl

    // Wait past the synchroniser and the latch edge before looking
    task automatic pin(input int b, input logic v);
        @(posedge ref_clk_i);
        want[b] <= v;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask : pin

    task automatic rt_chk(input logic fi, input logic st);
        `CHK("route", route(ctrl, fi, st), {pci, system_management_irq, leg})
    endtask : rt_chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        rd_chk(OFF_GEN_CTRL, GEN_CTRL_RESET);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        rd_chk(8'h7f, 8'h00);
        `CHK("card_rst", 1'b1, card_rst)
        $display("test 1 done");
        repeat (8)
        begin
            @(posedge ref_clk_i);
            is16 <= xs() > 32'h8000_0000;
            wr_ctrl(seed[7:0]);
            rd_chk(OFF_GEN_CTRL, ctrl);
            `CHK("card_rst", is16 & ~ctrl[6], card_rst)
        end
        // Unmapped writes must leave the control register alone
        rw(1'b1, 8'h05, 8'hff);
        rd_chk(OFF_GEN_CTRL, ctrl);
        $display("test 2 done");
        pin(PIN_FUNC_IRQ, 1'b1);
        for (int n = 0; n < 16; n++)
        begin
            wr_ctrl({4'h6, n[3:0]});
            rt_chk(1'b1, 1'b0);
        end
        pin(PIN_FUNC_IRQ, 1'b0);
        $display("test 3 done");
        @(posedge ref_clk_i);
        en <= 4'h8;
        wr_ctrl(8'h40);
        pin(PIN_CD1, 1'b1);
        rt_chk(1'b0, 1'b1);
        // Read-clear mode: a write of ones must not clear
        rw(1'b1, OFF_STATUS_CHANGE, 8'hff);
        rd_chk(OFF_STATUS_CHANGE, 8'h08);
        rt_chk(1'b0, 1'b0);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        @(posedge ref_clk_i);
        en <= 4'h0;
        pin(PIN_CD2, 1'b1);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        rt_chk(1'b0, 1'b0);
        $display("test 4 done");
        @(posedge ref_clk_i);
        en <= 4'h8;
        wo1 <= 1'b1;
        pin(PIN_CD1, 1'b0);
        for (int n = 0; n < 16; n++)
        begin
            @(posedge ref_clk_i);
            ls <= 4'(xs());
            wr_ctrl({3'b010, seed[7], n[3:0]});
            rt_chk(1'b0, 1'b1);
        end
        rd_chk(OFF_STATUS_CHANGE, 8'h08);
        rw(1'b1, OFF_STATUS_CHANGE, 8'h08);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        pin(PIN_CD2, 1'b0);
        rt_chk(1'b0, 1'b1);
        rw(1'b1, OFF_STATUS_CHANGE, 8'h07);
        rd_chk(OFF_STATUS_CHANGE, 8'h08);
        rw(1'b1, OFF_STATUS_CHANGE, 8'h08);
        rt_chk(1'b0, 1'b0);
        $display("test 5 done");
        @(posedge ref_clk_i);
        en <= 4'hf;
        wo1 <= 1'b0;
        wr_ctrl(8'h40);
        pin(PIN_READY, 1'b1);
        rd_chk(OFF_STATUS_CHANGE, 8'h04);
        pin(PIN_BVD1_RING, 1'b0);
        rd_chk(OFF_STATUS_CHANGE, 8'h02);
        pin(PIN_BATTERY_DETECT_TWO, 1'b0);
        rd_chk(OFF_STATUS_CHANGE, 8'h01);
        pin(PIN_BVD1_RING, 1'b1);
        pin(PIN_BATTERY_DETECT_TWO, 1'b1);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        wr_ctrl(8'h60);
        pin(PIN_READY, 1'b0);
        pin(PIN_READY, 1'b1);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        pin(PIN_BVD1_RING, 1'b0);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        pin(PIN_BVD1_RING, 1'b1);
        rd_chk(OFF_STATUS_CHANGE, 8'h01);
        $display("test 6 done");
        wr_ctrl(8'he0);
        rd_chk(OFF_STATUS_CHANGE, 8'h01);
        pin(PIN_BVD1_RING, 1'b0);
        rd_chk(OFF_STATUS_CHANGE, 8'h00);
        $display("test 7 done");
        tally_and_finish();
    end
endmodule : card_socket_irq_status_tb_top
